// ===== sfd_fan_ctrl.sv
// Top-level control logic of the single-phase fan motor driver.
// Functional notes
// RQ1: Sleep after speed and minimum levels stay above the ramp over 1.5ms.
// RQ2: Leave sleep into start-up once the speed level drops below the ramp.
// RQ3: Start-up drives on soft-start above ramp while charging, else regenerates.
// RQ4: Same soft-start sequence at power-up and after every lock restart.
// RQ5: After the eighth rotation edge, duty follows the speed reference.
// RQ6: Normal mode drives while ramp exceeds speed level, else regenerates.
// RQ7: Duty is clamped from below by the minimum-duty level.
// RQ8: Soft switching spans 18.75% of half period before and after switch.
// RQ9: Toward low-side drive, duty falls by one eighth each window step.
// RQ10: Toward PWM, duty rises by one eighth each window step.
// RQ11: A fixed 300us regeneration follows every phase switch; the first switch after reset gets none.
// RQ12: No Hall crossing within lock time turns high-side drives off.
// RQ13: After the off interval, lock shutdown retries via start-up.
// RQ14: Undervoltage flag puts both phase outputs into sleep.
// RQ15: Overvoltage flag disables high sides, low sides keep working.
// RQ16: Lock detection drive-on interval is 0.75 seconds.
// RQ17: Lock off interval before restart is 7 seconds.
// RQ18: Rotation pulse follows the Hall comparison directly.
// RQ19: Lock indicator low while rotating, released while locked.
// RQ20: All comparator and supply flags are synchronised before use.
// RQ21: Window positions are fractions of the last measured half period.
module sfd_fan_ctrl #(
	parameter int unsigned CNT_W = 32,
	parameter int unsigned SLEEP_CYCLES = sfd_pkg::SLEEP_DWELL_CYC,
	parameter int unsigned REGEN_CYCLES = sfd_pkg::REGEN_HOLD_CYC,
	parameter int unsigned LOCK_ON_CYCLES = sfd_pkg::LOCK_ON_CYC,
	parameter int unsigned LOCK_OFF_CYCLES = sfd_pkg::LOCK_OFF_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ramp_above_ref_i,
	input wire logic ramp_above_min_i,
	input wire logic soft_start_above_ramp_i,
	input wire logic ramp_charging_i,
	input wire logic hall_pos_above_neg_i,
	input wire logic supply_low_lockout_i,
	input wire logic supply_high_guard_i,
	output logic bridge_out_a_hi_o,
	output logic bridge_out_a_lo_o,
	output logic bridge_out_b_hi_o,
	output logic bridge_out_b_lo_o,
	output logic rotation_pulse_o,
	output logic rotation_pulse_oe_o,
	output logic lock_ind_o,
	output logic lock_ind_oe_o
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	// Counters must hold the 7 s off interval at the full clock rate.
	if (CNT_W < 32 || CNT_W > 62)
		$error("CNT_W must lie between 32 and 62");
	if (SLEEP_CYCLES < 1 || LOCK_ON_CYCLES < 1 || LOCK_OFF_CYCLES < 1)
		$error("timing counts must be at least one cycle");

	// ==========================================================
	// Declarations
	// ==========================================================
	localparam int unsigned NSYNC = 7;

	logic [NSYNC-1:0] sync_in;
	logic ramp_above_ref;
	logic ramp_above_min;
	logic ss_above_ramp;
	logic ramp_charging;
	logic hall_cmp;
	logic uv_flag;
	logic ov_flag;

	sfd_pkg::sfd_state_t state_reg;
	sfd_pkg::sfd_state_t state_next;
	logic hall_prev_reg;
	logic hall_edge;
	logic [CNT_W-1:0] idle_cnt_reg;
	logic [CNT_W-1:0] lock_cnt_reg;
	logic [CNT_W-1:0] off_cnt_reg;
	logic [3:0] edge_cnt_reg;
	logic [CNT_W-1:0] run_cnt_reg;
	logic [CNT_W-1:0] on_len_reg;
	logic raw_drive_reg;
	logic [sfd_pkg::LEVEL_W-1:0] level;
	logic sleep_req;
	logic lock_hit;
	logic raw_drive;
	logic pwm_on;
	logic hi_en;
	logic lo_en;

	// Scales a pulse length by a level given in eighths.
	function automatic logic [CNT_W-1:0] scale_len(
		input logic [CNT_W-1:0] len,
		input logic [sfd_pkg::LEVEL_W-1:0] lvl
	);
		logic [CNT_W+sfd_pkg::LEVEL_W-1:0] prod;
		prod = len * lvl;
		return CNT_W'(prod >> sfd_pkg::LEVEL_SHIFT);
	endfunction

	// ==========================================================
	// Input synchronisation
	// ==========================================================
	sfd_sync #(
		.WIDTH(NSYNC)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i({ramp_above_ref_i, ramp_above_min_i,
			soft_start_above_ramp_i, ramp_charging_i,
			hall_pos_above_neg_i, supply_low_lockout_i,
			supply_high_guard_i}),
		.sync_o(sync_in)
	); // RQ20

	assign {ramp_above_ref, ramp_above_min, ss_above_ramp, ramp_charging,
		hall_cmp, uv_flag, ov_flag} = sync_in;

	assign hall_edge = hall_cmp != hall_prev_reg;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			hall_prev_reg <= 1'b0;
		else
			hall_prev_reg <= hall_cmp;
	end

	// ==========================================================
	// Soft switching sequencer
	// ==========================================================
	sfd_soft_switch #(
		.CNT_W(CNT_W),
		.REGEN_CYCLES(REGEN_CYCLES)
	) u_soft (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.hall_edge_i(hall_edge),
		.level_o(level)
	);

	// ==========================================================
	// Sleep dwell and lock timers
	// ==========================================================
	assign sleep_req = idle_cnt_reg >= CNT_W'(SLEEP_CYCLES);
	assign lock_hit = lock_cnt_reg >= CNT_W'(LOCK_ON_CYCLES);

	// Any moment with the ramp above either level restarts the dwell.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			idle_cnt_reg <= '0;
		else if (ramp_above_ref || ramp_above_min)
			idle_cnt_reg <= '0;
		else if (!sleep_req)
			idle_cnt_reg <= idle_cnt_reg + 1'b1; // RQ1
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			lock_cnt_reg <= '0;
		else if (hall_edge || state_reg == sfd_pkg::SFD_SLEEP
			|| state_reg == sfd_pkg::SFD_LOCKED)
			lock_cnt_reg <= '0;
		else if (!lock_hit)
			lock_cnt_reg <= lock_cnt_reg + 1'b1; // RQ16
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			off_cnt_reg <= '0;
		else if (state_reg != sfd_pkg::SFD_LOCKED)
			off_cnt_reg <= '0;
		else
			off_cnt_reg <= off_cnt_reg + 1'b1; // RQ17
	end

	// Edges are counted afresh on every entry into start-up.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			edge_cnt_reg <= '0;
		else if (state_reg != sfd_pkg::SFD_START)
			edge_cnt_reg <= '0;
		else if (hall_edge)
			edge_cnt_reg <= edge_cnt_reg + 1'b1; // RQ5
	end

	// ==========================================================
	// Operating state machine
	// ==========================================================
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			sfd_pkg::SFD_SLEEP:
				if (ramp_above_ref)
					state_next = sfd_pkg::SFD_START; // RQ2
			sfd_pkg::SFD_START:
				if (sleep_req)
					state_next = sfd_pkg::SFD_SLEEP; // RQ1
				else if (lock_hit)
					state_next = sfd_pkg::SFD_LOCKED; // RQ12
				else if (edge_cnt_reg == 4'(sfd_pkg::START_EDGES))
					state_next = sfd_pkg::SFD_RUN; // RQ5
			sfd_pkg::SFD_RUN:
				if (sleep_req)
					state_next = sfd_pkg::SFD_SLEEP; // RQ1
				else if (lock_hit)
					state_next = sfd_pkg::SFD_LOCKED; // RQ12
			sfd_pkg::SFD_LOCKED:
				if (off_cnt_reg + 1'b1 >= CNT_W'(LOCK_OFF_CYCLES))
					state_next = sfd_pkg::SFD_START; // RQ13 RQ4
			default:
				state_next = sfd_pkg::SFD_SLEEP;
		endcase
	end

	// Undervoltage parks the machine in sleep until the supply returns.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			state_reg <= sfd_pkg::SFD_SLEEP;
		else if (uv_flag)
			state_reg <= sfd_pkg::SFD_SLEEP; // RQ14
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// PWM decision and soft-switching scaling
	// ==========================================================
	always_comb
	begin
		raw_drive = 1'b0;
		if (state_reg == sfd_pkg::SFD_START)
			raw_drive = ss_above_ramp && ramp_charging; // RQ3 RQ4
		else if (state_reg == sfd_pkg::SFD_RUN)
			raw_drive = ramp_above_ref || ramp_above_min; // RQ6 RQ7
	end

	// The previous drive pulse stands in for the actual duty, so a
	// scaled pulse lags the comparators by one PWM period.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			raw_drive_reg <= 1'b0;
			run_cnt_reg <= '0;
			on_len_reg <= '0;
		end
		else
		begin
			raw_drive_reg <= raw_drive;
			if (raw_drive)
				run_cnt_reg <= run_cnt_reg + 1'b1;
			else
				run_cnt_reg <= '0;
			if (raw_drive_reg && !raw_drive)
				on_len_reg <= run_cnt_reg;
		end
	end

	assign pwm_on = raw_drive && (level == sfd_pkg::LEVEL_FULL
		|| run_cnt_reg < scale_len(on_len_reg, level)); // RQ9 RQ10

	// ==========================================================
	// Bridge outputs
	// ==========================================================
	assign hi_en = !uv_flag && !ov_flag && (state_reg == sfd_pkg::SFD_START
		|| state_reg == sfd_pkg::SFD_RUN); // RQ12 RQ15
	assign lo_en = !uv_flag && state_reg != sfd_pkg::SFD_SLEEP; // RQ14

	// Hall low drives phase a high and holds phase b low.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			bridge_out_a_hi_o <= 1'b0;
			bridge_out_a_lo_o <= 1'b0;
			bridge_out_b_hi_o <= 1'b0;
			bridge_out_b_lo_o <= 1'b0;
		end
		else
		begin
			bridge_out_a_hi_o <= hi_en && pwm_on && !hall_cmp;
			bridge_out_b_hi_o <= hi_en && pwm_on && hall_cmp;
			bridge_out_a_lo_o <= lo_en && hall_cmp; // RQ15
			bridge_out_b_lo_o <= lo_en && !hall_cmp; // RQ15
		end
	end

	// ==========================================================
	// Open-drain status pins
	// ==========================================================
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rotation_pulse_o <= 1'b0;
			rotation_pulse_oe_o <= 1'b0;
			lock_ind_o <= 1'b0;
			lock_ind_oe_o <= 1'b0;
		end
		else
		begin
			rotation_pulse_o <= 1'b0;
			rotation_pulse_oe_o <= !hall_cmp; // RQ18
			lock_ind_o <= 1'b0;
			lock_ind_oe_o <= state_reg != sfd_pkg::SFD_LOCKED; // RQ19
		end
	end

endmodule

// ===== sfd_fan_ctrl_assertions.sv
// Concurrent checks on the ports of the fan drive control logic.
module sfd_fan_ctrl_chk #(
	parameter int unsigned LOCK_ON_CYCLES = 2000,
	parameter int unsigned LOCK_OFF_CYCLES = 5000
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hall_pos_above_neg_i,
	input wire logic supply_low_lockout_i,
	input wire logic supply_high_guard_i,
	input wire logic bridge_out_a_hi_o,
	input wire logic bridge_out_a_lo_o,
	input wire logic bridge_out_b_hi_o,
	input wire logic bridge_out_b_lo_o,
	input wire logic rotation_pulse_o,
	input wire logic rotation_pulse_oe_o,
	input wire logic lock_ind_o,
	input wire logic lock_ind_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// Helper counters
	// ==========
	logic [2:0] up_cnt;
	logic [31:0] idle_cnt;
	logic [31:0] off_cnt;
	logic seen_hi;
	logic hall_d;
	logic hall_seen;
	// The idle count runs on the raw Hall level, so it is always a little
	// ahead of the design's synchronised count; that only loosens the check.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			up_cnt <= 3'h0;
			idle_cnt <= 32'h0;
			off_cnt <= 32'h0;
			seen_hi <= 1'b0;
			hall_seen <= 1'b0;
		end
		else
		begin
			hall_seen <= hall_seen | (hall_pos_above_neg_i != hall_d);
			if (up_cnt != 3'h7)
				up_cnt <= up_cnt + 3'h1;
			idle_cnt <= (hall_pos_above_neg_i != hall_d) ? 32'h0 :
				idle_cnt + 32'h1;
			off_cnt <= (lock_ind_oe_o || !seen_hi) ? 32'h0 :
				off_cnt + 32'h1;
			seen_hi <= seen_hi | lock_ind_oe_o;
		end
		hall_d <= hall_pos_above_neg_i;
	end

	// ==========
	// Properties
	// ==========
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence uv_held_s;
		supply_low_lockout_i[*5];
	endsequence
	sequence hall_lo_s;
		!hall_pos_above_neg_i[*5];
	endsequence
	sequence hall_hi_s;
		hall_pos_above_neg_i[*5];
	endsequence
	sequence hi_off_s;
		(!bridge_out_a_hi_o && !bridge_out_b_hi_o)[*8];
	endsequence

	rot_follow_a: assert property (up_cnt == 3'h7 |->
		rotation_pulse_oe_o == !$past(hall_pos_above_neg_i, 3))
		else $error("rotation pulse does not follow the Hall level");
	od_data_a: assert property (!rotation_pulse_o && !lock_ind_o)
		else $error("open-drain data line driven high");
	drive_pair_a: assert property ((bridge_out_a_hi_o |->
		bridge_out_b_lo_o && !bridge_out_a_lo_o && !bridge_out_b_hi_o) and
		(bridge_out_b_hi_o |-> bridge_out_a_lo_o && !bridge_out_b_lo_o))
		else $error("high side on without its opposite low side");
	phase_sel_a: assert property ((hall_lo_s |-> !bridge_out_b_hi_o &&
		!bridge_out_a_lo_o) and (hall_hi_s |-> !bridge_out_a_hi_o &&
		!bridge_out_b_lo_o))
		else $error("wrong phase driven for the Hall level");
	uv_off_a: assert property (uv_held_s |->
		{bridge_out_a_hi_o, bridge_out_a_lo_o, bridge_out_b_hi_o,
		bridge_out_b_lo_o} == 4'h0)
		else $error("bridge active under undervoltage");
	ov_high_a: assert property (supply_high_guard_i[*5] |->
		!bridge_out_a_hi_o && !bridge_out_b_hi_o)
		else $error("high side on under overvoltage");
	lock_early_a: assert property ($fell(lock_ind_oe_o) |->
		idle_cnt >= LOCK_ON_CYCLES)
		else $error("lock declared while the Hall level was changing");
	lock_hold_a: assert property ($fell(lock_ind_oe_o) |-> hi_off_s)
		else $error("high side on after lock detection");
	lock_off_a: assert property ($rose(lock_ind_oe_o) && seen_hi |->
		off_cnt >= LOCK_OFF_CYCLES - 2 && off_cnt <= LOCK_OFF_CYCLES + 8)
		else $error("lock off interval of wrong length");
	// The first crossing has no measured half period, so it is skipped.
	regen_gap_a: assert property (hall_seen &&
		hall_pos_above_neg_i != hall_d |-> ##5 hi_off_s)
		else $error("high side on during the regeneration gap");
endmodule

bind sfd_fan_ctrl sfd_fan_ctrl_chk #(
	.LOCK_ON_CYCLES(LOCK_ON_CYCLES),
	.LOCK_OFF_CYCLES(LOCK_OFF_CYCLES)
) chk_i (
	.sys_clk_i,
	.rst_i,
	.hall_pos_above_neg_i,
	.supply_low_lockout_i,
	.supply_high_guard_i,
	.bridge_out_a_hi_o,
	.bridge_out_a_lo_o,
	.bridge_out_b_hi_o,
	.bridge_out_b_lo_o,
	.rotation_pulse_o,
	.rotation_pulse_oe_o,
	.lock_ind_o,
	.lock_ind_oe_o
);

// ===== sfd_motor_model.sv
// Hall sensor and rotor model: crossings come every fixed half period.
module sfd_motor_model #(
	parameter int unsigned HALF = 400
) (
	input wire logic sys_clk_i,
	input wire logic spin_i,
	output logic hall_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned ph_cnt = 0;
	initial hall_o = 1'b0;
	// A stalled rotor keeps its position, so the comparator holds its level.
	always @(posedge sys_clk_i)
	begin
		if (spin_i)
		begin
			ph_cnt <= (ph_cnt == HALF - 1) ? 0 : ph_cnt + 1;
			if (ph_cnt == HALF - 1)
				hall_o <= ~hall_o;
		end
	end
endmodule

// ===== sfd_pkg.sv
// Shared constants of the single-phase fan drive control logic.
package sfd_pkg;

	// ==========================================================
	// Clock and timing figures
	// ==========================================================
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned SLEEP_DWELL_NS = 1500000;
	localparam int unsigned REGEN_HOLD_NS = 300000;
	localparam int unsigned LOCK_ON_MS = 750;
	localparam int unsigned LOCK_OFF_MS = 7000;
	localparam int unsigned NS_PER_MS = 1000000;

	// Least times round up, so a partial cycle still counts in full.
	localparam int unsigned SLEEP_DWELL_CYC =
		(SLEEP_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REGEN_HOLD_CYC =
		(REGEN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCK_ON_CYC =
		LOCK_ON_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned LOCK_OFF_CYC =
		LOCK_OFF_MS * (NS_PER_MS / CLK_PERIOD_NS);

	// ==========================================================
	// Start-up and soft switching
	// ==========================================================
	localparam int unsigned START_EDGES = 8;
	localparam int unsigned STEP_W = 3;
	localparam int unsigned LEVEL_W = 4;
	localparam logic [LEVEL_W-1:0] LEVEL_FULL = 4'h8;
	localparam logic [LEVEL_W-1:0] LEVEL_OFF = 4'h0;
	localparam logic [STEP_W-1:0] STEP_LAST = 3'h7;
	// Window is 3/16 of a half period, each step 1/8 of the window.
	localparam int unsigned WIN_MUL = 3;
	localparam int unsigned WIN_SHIFT = 4;
	localparam int unsigned STEP_SHIFT = 7;
	localparam int unsigned LEVEL_SHIFT = 3;

	// ==========================================================
	// Operating states
	// ==========================================================
	typedef enum logic [3:0] {
		SFD_SLEEP = 4'b0001,
		SFD_START = 4'b0010,
		SFD_RUN = 4'b0100,
		SFD_LOCKED = 4'b1000
	} sfd_state_t;

endpackage

// ===== sfd_soft_switch.sv
// Half-period measurement and soft-switching duty level sequencer.
module sfd_soft_switch #(
	parameter int unsigned CNT_W = 32,
	parameter int unsigned REGEN_CYCLES = sfd_pkg::REGEN_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hall_edge_i,
	output logic [sfd_pkg::LEVEL_W-1:0] level_o
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] half_reg;
	logic [CNT_W-1:0] win_start_reg;
	logic [CNT_W-1:0] step_len_reg;
	logic [CNT_W-1:0] sub_reg;
	logic [CNT_W-1:0] regen_reg;
	logic [sfd_pkg::STEP_W-1:0] step_reg;
	logic valid_reg;
	logic up_reg;
	logic down_reg;
	logic stepping;
	logic step_tick;
	logic [CNT_W+1:0] half_x3;

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	// The product of a count and the window factor must stay in range.
	if (CNT_W < 8 || CNT_W > 62)
		$error("CNT_W must lie between 8 and 62");

	assign half_x3 = {2'b00, cnt_reg} * (CNT_W+2)'(sfd_pkg::WIN_MUL);
	assign stepping = (up_reg && regen_reg == '0) || down_reg;
	assign step_tick = stepping && (sub_reg + 1'b1 >= step_len_reg);

	// ==========================================================
	// Half-period measurement
	// ==========================================================
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg <= '0;
			half_reg <= '0;
			win_start_reg <= '0;
			step_len_reg <= '0;
			valid_reg <= 1'b0;
		end
		else if (hall_edge_i)
		begin
			cnt_reg <= '0;
			half_reg <= cnt_reg; // RQ21
			win_start_reg <= cnt_reg
				- CNT_W'(half_x3 >> sfd_pkg::WIN_SHIFT); // RQ8
			step_len_reg <= CNT_W'(half_x3 >> sfd_pkg::STEP_SHIFT);
			valid_reg <= 1'b1;
		end
		else if (cnt_reg != '1)
			cnt_reg <= cnt_reg + 1'b1;
	end

	// ==========================================================
	// Step sequencing around each phase switch
	// ==========================================================
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			regen_reg <= '0;
			up_reg <= 1'b0;
			down_reg <= 1'b0;
			step_reg <= '0;
			sub_reg <= '0;
		end
		else if (hall_edge_i)
		begin
			regen_reg <= CNT_W'(REGEN_CYCLES); // RQ11
			up_reg <= valid_reg;
			down_reg <= 1'b0;
			step_reg <= '0;
			sub_reg <= '0;
		end
		else
		begin
			if (regen_reg != '0)
				regen_reg <= regen_reg - 1'b1;
			if (valid_reg && !up_reg && !down_reg
				&& cnt_reg == win_start_reg && half_reg != '0)
			begin
				down_reg <= 1'b1; // RQ8
				step_reg <= '0;
				sub_reg <= '0;
			end
			else if (step_tick)
			begin
				sub_reg <= '0;
				if (step_reg != sfd_pkg::STEP_LAST)
					step_reg <= step_reg + 1'b1;
				else if (up_reg)
					up_reg <= 1'b0;
			end
			else if (stepping)
				sub_reg <= sub_reg + 1'b1;
		end
	end

	// ==========================================================
	// Duty level in eighths of the actual duty
	// ==========================================================
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			level_o <= sfd_pkg::LEVEL_FULL;
		else if (up_reg && regen_reg != '0)
			level_o <= sfd_pkg::LEVEL_OFF; // RQ11
		else if (up_reg)
			level_o <= {1'b0, step_reg} + 1'b1; // RQ10
		else if (down_reg)
			level_o <= {1'b0, sfd_pkg::STEP_LAST - step_reg}; // RQ9
		else
			level_o <= sfd_pkg::LEVEL_FULL;
	end

endmodule

// ===== sfd_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
module sfd_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// Synchroniser
	// ==========================================================
	// The first stage feeds only the second stage.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule

// ===== testbench.sv
// Self-checking bench for the fan drive control logic.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned LON = 2000;
	localparam int unsigned LOFF = 5000;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic above_ref = 1'b0;
	logic above_min = 1'b0;
	logic soft_above = 1'b0;
	logic charging = 1'b0;
	logic uv = 1'b0;
	logic ov = 1'b0;
	logic spin = 1'b0;
	logic hall, a_hi, a_lo, b_hi, b_lo, fg_d, fg_oe, rd_d, rd_oe;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;

	sfd_fan_ctrl #(.SLEEP_CYCLES(50), .REGEN_CYCLES(20),
		.LOCK_ON_CYCLES(LON), .LOCK_OFF_CYCLES(LOFF)) uut (
		.sys_clk_i(sys_clk), .rst_i(rst), .ramp_above_ref_i(above_ref),
		.ramp_above_min_i(above_min), .soft_start_above_ramp_i(soft_above),
		.ramp_charging_i(charging), .hall_pos_above_neg_i(hall),
		.supply_low_lockout_i(uv), .supply_high_guard_i(ov),
		.bridge_out_a_hi_o(a_hi), .bridge_out_a_lo_o(a_lo),
		.bridge_out_b_hi_o(b_hi), .bridge_out_b_lo_o(b_lo),
		.rotation_pulse_o(fg_d), .rotation_pulse_oe_o(fg_oe),
		.lock_ind_o(rd_d), .lock_ind_oe_o(rd_oe)
	);
	sfd_motor_model #(.HALF(400)) motor (.sys_clk_i(sys_clk),
		.spin_i(spin), .hall_o(hall));

	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ==========
	// Shared tasks
	// ==========
	task automatic complete_run();
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// Outputs are read at the falling edge, well clear of their updates.
	task automatic look(input logic [3:0] exp);
		@(negedge sys_clk);
		chk({a_hi, a_lo, b_hi, b_lo}, exp);
		@(posedge sys_clk);
	endtask
	function automatic logic [3:0] drive(input logic h);
		return h ? 4'h6 : 4'h9;
	endfunction
	function automatic logic [3:0] regen(input logic h);
		return h ? 4'h4 : 4'h1;
	endfunction
	task automatic next_hall();
		logic h;
		h = hall;
		n = 0;
		while (hall === h && n < 1000)
		begin
			tick(1);
			n++;
		end
		if (n >= 1000)
			error_cnt++;
	endtask

	// ==========
	// Scenarios
	// ==========
	task automatic t_wake();
		look(4'h0);
		above_ref <= 1'b1;
		soft_above <= 1'b1;
		charging <= 1'b1;
		tick(6);
		look(drive(hall));
		charging <= 1'b0;
		tick(6);
		look(regen(hall));
		charging <= 1'b1;
		soft_above <= 1'b0;
		tick(6);
		look(regen(hall));
	endtask
	task automatic t_handover();
		spin <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			next_hall();
			tick(200);
			look(i == 7 ? drive(hall) : regen(hall));
		end
	endtask
	task automatic t_duty();
		next_hall();
		tick(8);
		look(regen(hall));
		tick(111);
		above_ref <= 1'b0;
		above_min <= 1'b1;
		tick(6);
		@(negedge sys_clk);
		chk({a_hi, a_lo, b_hi, b_lo}, drive(hall));
		chk({3'h0, fg_oe}, {3'h0, !hall});
		@(posedge sys_clk);
		above_min <= 1'b0;
		tick(6);
		look(regen(hall));
		above_ref <= 1'b1;
		tick(6);
		look(drive(hall));
	endtask
	task automatic t_sleep();
		next_hall();
		tick(30);
		above_ref <= 1'b0;
		tick(45);
		look(regen(hall));
		tick(15);
		look(4'h0);
		above_ref <= 1'b1;
		tick(6);
		look(regen(hall));
	endtask
	task automatic t_lock();
		soft_above <= 1'b1;
		next_hall();
		spin <= 1'b0;
		n = 0;
		while (rd_oe !== 1'b0 && n < LON + 100)
		begin
			tick(1);
			n++;
		end
		chk({3'h0, n >= LON && n <= LON + 10}, 4'h1);
		@(negedge sys_clk);
		chk({a_hi, a_lo, b_hi, b_lo}, regen(hall));
		chk({2'h0, rd_d, rd_oe}, 4'h0);
		@(posedge sys_clk);
		charging <= 1'b0;
		n = 0;
		while (rd_oe !== 1'b1 && n < LOFF + 100)
		begin
			tick(1);
			n++;
		end
		chk({3'h0, n >= LOFF - 2 && n <= LOFF + 10}, 4'h1);
		spin <= 1'b1;
		next_hall();
		tick(200);
		look(regen(hall));
		charging <= 1'b1;
		tick(6);
		look(drive(hall));
	endtask
	task automatic t_supply();
		next_hall();
		tick(120);
		ov <= 1'b1;
		tick(6);
		look(regen(hall));
		ov <= 1'b0;
		tick(6);
		look(drive(hall));
		uv <= 1'b1;
		tick(6);
		look(4'h0);
		uv <= 1'b0;
	endtask

	// A run is about 12000 cycles; the ceiling leaves ample margin.
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	initial
	begin
		tick(20);
		rst <= 1'b0;
		tick(4);
		t_wake();
		t_handover();
		t_duty();
		t_sleep();
		t_lock();
		t_supply();
		complete_run();
	end
endmodule
